// ==== gio_ctrl.sv ====
// gio_ctrl: debounce, edge tally, direct mapping, pwm, serial settings,
// watchdog and save/restore of one controller group.
// assumes a one-word register port from the same clock and raw switch pins.
`timescale 1ns/1ps
`default_nettype none

module gio_ctrl
   import gio_pkg::*;
#(
   parameter int NUM_IN = 4,
   parameter int NUM_OUT = 4,
   parameter int TXQ_DEPTH = 64,
   parameter int MS_CYC = GIO_MS_CYC,
   parameter logic [15:0] FW_VERSION = 16'h0100,  // arbitrary value
   parameter logic [15:0] BOARD_REV = 16'h0011,   // arbitrary value
   parameter logic [31:0] BOARD_SERNO = 32'h00000001, // arbitrary value
   parameter logic [3:0] NUM_AI = 4'h0,
   parameter logic [3:0] NUM_AO = 4'h0,
   parameter logic [3:0] NUM_SER = 4'h1
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // switch inputs and outputs
   input wire logic [NUM_IN-1:0] switch_in,
   output logic [NUM_OUT-1:0] relay_out,
   // serial datapath side
   input wire logic ser_rx_not_empty,
   input wire logic ser_tx_done,
   input wire logic ser_byte_sent,
   input wire logic ser_frame_done,
   output logic tx_push,
   output logic [7:0] tx_data,
   output logic [2:0] ser_baud,
   output logic ser_parity_en,
   output logic ser_parity_odd,
   output logic ser_rtu_en,
   // misc
   output logic single_wire_disable,
   output logic watchdog_reboot_flag
);

   localparam int TQW = $clog2(TXQ_DEPTH + 1);
   localparam int MSW = $clog2(MS_CYC + 1);
   localparam logic [11:0] DEB_LAST = 12'(GIO_DEB_TICK_CYC - 1);
   localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYC - 1);
   localparam logic [TQW-1:0] TQ_FULL = TQW'(TXQ_DEPTH);

   function automatic logic wr_at(input logic [7:0] a);
      wr_at = reg_wr && (reg_addr == a);
   endfunction

   function automatic gio_baud_t speed_decode(input logic [12:0] s);
      case (s)
         13'd11: speed_decode = GIO_BAUD_2400;
         13'd12: speed_decode = GIO_BAUD_4800;
         13'd13: speed_decode = GIO_BAUD_9600;
         13'd14: speed_decode = GIO_BAUD_19200;
         13'd15: speed_decode = GIO_BAUD_38400;
         13'd4097: speed_decode = GIO_BAUD_57600;
         13'd4098: speed_decode = GIO_BAUD_115200;
         default: speed_decode = GIO_BAUD_NONE;
      endcase
   endfunction

   // settings and their saved copies
   gio_cfg_t cfg_ff, dflt_cfg_ff;
   logic [NUM_OUT-1:0] out_level_ff, dflt_out_level_ff;
   logic [NUM_OUT-1:0] pwm_en_ff, dflt_pwm_en_ff;
   logic [NUM_IN-1:0] map_en_ff, map_inv_ff, map_tog_ff;
   logic [NUM_IN-1:0] dflt_map_en_ff, dflt_map_inv_ff, dflt_map_tog_ff;
   logic [15:0] pwm_val_ff [NUM_OUT];
   logic [15:0] dflt_pwm_val_ff [NUM_OUT];
   logic sw_disable_ff, wd_en_ff, wd_flag_ff;
   logic [15:0] wd_timeout_ff;
   logic restore;
   logic wd_fire;

   // reboot by command or by watchdog reloads the saved defaults
   always_comb restore = (wr_at(GIO_A_REBOOT) && reg_wdata[0]) || wd_fire;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dflt_cfg_ff <= GIO_RST_CFG;
         dflt_out_level_ff <= '0;
         dflt_pwm_en_ff <= '0;
         dflt_map_en_ff <= '0;
         dflt_map_inv_ff <= '0;
         dflt_map_tog_ff <= '0;
         for (int i = 0; i < NUM_OUT; i++) dflt_pwm_val_ff[i] <= 16'h0000;
      end else if (wr_at(GIO_A_SAVE) && reg_wdata[0]) begin
         dflt_cfg_ff <= cfg_ff;
         dflt_out_level_ff <= out_level_ff;
         dflt_pwm_en_ff <= pwm_en_ff;
         dflt_map_en_ff <= map_en_ff;
         dflt_map_inv_ff <= map_inv_ff;
         dflt_map_tog_ff <= map_tog_ff;
         for (int i = 0; i < NUM_OUT; i++) dflt_pwm_val_ff[i] <= pwm_val_ff[i];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_ff <= GIO_RST_CFG;
         out_level_ff <= '0;
         pwm_en_ff <= '0;
         map_en_ff <= '0;
         map_inv_ff <= '0;
         map_tog_ff <= '0;
         for (int i = 0; i < NUM_OUT; i++) pwm_val_ff[i] <= 16'h0000;
      end else if (restore) begin
         cfg_ff <= dflt_cfg_ff;
         out_level_ff <= dflt_out_level_ff;
         pwm_en_ff <= dflt_pwm_en_ff;
         map_en_ff <= dflt_map_en_ff;
         map_inv_ff <= dflt_map_inv_ff;
         map_tog_ff <= dflt_map_tog_ff;
         for (int i = 0; i < NUM_OUT; i++) pwm_val_ff[i] <= dflt_pwm_val_ff[i];
      end else begin
         if (wr_at(GIO_A_OUT_LEVEL)) out_level_ff <= reg_wdata[NUM_OUT-1:0];
         if (wr_at(GIO_A_PWM_EN)) pwm_en_ff <= reg_wdata[NUM_OUT-1:0];
         if (wr_at(GIO_A_MAP_EN)) map_en_ff <= reg_wdata[NUM_IN-1:0];
         if (wr_at(GIO_A_MAP_INV)) map_inv_ff <= reg_wdata[NUM_IN-1:0];
         if (wr_at(GIO_A_MAP_TOG)) map_tog_ff <= reg_wdata[NUM_IN-1:0];
         if (wr_at(GIO_A_DEBOUNCE)) cfg_ff.debounce <= reg_wdata;
         if (wr_at(GIO_A_PRESCALE)) cfg_ff.prescale <= reg_wdata;
         if (wr_at(GIO_A_CYCLE)) cfg_ff.cycle <= reg_wdata;
         if (wr_at(GIO_A_SERIAL_CFG)) cfg_ff.serial <= reg_wdata;
         for (int i = 0; i < NUM_OUT; i++) begin
            if (wr_at(GIO_A_PWM_VAL + 8'(i))) begin
               // values above the cycle are limited to it
               if (reg_wdata > cfg_ff.cycle) pwm_val_ff[i] <= cfg_ff.cycle;
               else pwm_val_ff[i] <= reg_wdata;
            end
         end
      end
   end

   // bits outside the saved set
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sw_disable_ff <= 1'b0;
         wd_en_ff <= 1'b0;
         wd_timeout_ff <= GIO_RST_WD_TIMEOUT;
      end else begin
         if (wr_at(GIO_A_SW_DISABLE)) sw_disable_ff <= reg_wdata[0];
         if (wr_at(GIO_A_WD_EN)) wd_en_ff <= reg_wdata[0];
         if (wr_at(GIO_A_WD_TIMEOUT)) wd_timeout_ff <= reg_wdata;
      end
   end

   // master watchdog: any register access counts as communication
   logic [MSW-1:0] ms_cnt_ff;
   logic [15:0] idle_ms_ff;
   logic ms_tick;
   assign ms_tick = (ms_cnt_ff == MS_LAST);
   assign wd_fire = wd_en_ff && !(reg_wr || reg_rd) && ms_tick
                    && (idle_ms_ff + 16'h0001 >= wd_timeout_ff);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ms_cnt_ff <= '0;
         idle_ms_ff <= 16'h0000;
      end else if (reg_wr || reg_rd || !wd_en_ff || wd_fire) begin
         ms_cnt_ff <= '0;
         idle_ms_ff <= 16'h0000;
      end else if (ms_tick) begin
         ms_cnt_ff <= '0;
         if (idle_ms_ff != 16'hFFFF) idle_ms_ff <= idle_ms_ff + 16'h0001;
      end else begin
         ms_cnt_ff <= ms_cnt_ff + MSW'(1);
      end
   end

   // a clear write is an access and so blocks firing in its cycle; the clear wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) wd_flag_ff <= 1'b0;
      else if (wd_fire) wd_flag_ff <= 1'b1;
      else if (wr_at(GIO_A_WD_CLEAR)) wd_flag_ff <= 1'b0;
   end

   // input synchronisers
   logic [NUM_IN-1:0] in_s1_ff, in_s2_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         in_s1_ff <= '0;
         in_s2_ff <= '0;
      end else begin
         in_s1_ff <= switch_in;
         in_s2_ff <= in_s1_ff;
      end
   end

   // 100 us tick shared by all debouncers
   logic [11:0] deb_cnt_ff;
   logic deb_tick;
   assign deb_tick = (deb_cnt_ff == DEB_LAST);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) deb_cnt_ff <= 12'h000;
      else if (deb_tick) deb_cnt_ff <= 12'h000;
      else deb_cnt_ff <= deb_cnt_ff + 12'h001;
   end

   // a change is taken once it has lasted setting+1 ticks, which holds
   // it for at least the full window whatever the tick phase
   logic [NUM_IN-1:0] in_state_ff;
   logic [NUM_IN-1:0] rise, fall;
   logic [15:0] hold_ff [NUM_IN];
   always_comb begin
      for (int i = 0; i < NUM_IN; i++) begin
         rise[i] = (in_s2_ff[i] != in_state_ff[i]) && in_s2_ff[i] && deb_tick
                   && (hold_ff[i] == cfg_ff.debounce);
         fall[i] = (in_s2_ff[i] != in_state_ff[i]) && !in_s2_ff[i] && deb_tick
                   && (hold_ff[i] == cfg_ff.debounce);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         in_state_ff <= '0;
         for (int i = 0; i < NUM_IN; i++) hold_ff[i] <= 16'h0000;
      end else begin
         for (int i = 0; i < NUM_IN; i++) begin
            if (in_s2_ff[i] == in_state_ff[i] || rise[i] || fall[i]) begin
               hold_ff[i] <= 16'h0000;
               if (rise[i] || fall[i]) in_state_ff[i] <= in_s2_ff[i];
            end else if (deb_tick && hold_ff[i] != 16'hFFFF) begin
               hold_ff[i] <= hold_ff[i] + 16'h0001;
            end
         end
      end
   end

   // edge tallies; an edge in the preset cycle counts on top of the preset
   logic [15:0] tally_ff [NUM_IN];
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_IN; i++) tally_ff[i] <= 16'h0000;
      end else begin
         for (int i = 0; i < NUM_IN; i++) begin
            if (wr_at(GIO_A_PRESET + 8'(i)))
               tally_ff[i] <= reg_wdata + {15'h0000, rise[i]};
            else if (rise[i])
               tally_ff[i] <= tally_ff[i] + 16'h0001;
         end
      end
   end

   // shared pwm timebase
   logic [15:0] pre_cnt_ff, cyc_cnt_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_cnt_ff <= 16'h0000;
         cyc_cnt_ff <= 16'h0000;
      end else if (pre_cnt_ff >= cfg_ff.prescale) begin
         pre_cnt_ff <= 16'h0000;
         if (cyc_cnt_ff >= cfg_ff.cycle) cyc_cnt_ff <= 16'h0000;
         else cyc_cnt_ff <= cyc_cnt_ff + 16'h0001;
      end else begin
         pre_cnt_ff <= pre_cnt_ff + 16'h0001;
      end
   end

   // pwm runs once the level falls 1 to 0 with a nonzero value
   logic [NUM_OUT-1:0] pwm_run_ff, prev_level_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pwm_run_ff <= '0;
         prev_level_ff <= '0;
      end else begin
         prev_level_ff <= out_level_ff;
         for (int i = 0; i < NUM_OUT; i++) begin
            if (out_level_ff[i] || !pwm_en_ff[i] || restore)
               pwm_run_ff[i] <= 1'b0;
            else if (prev_level_ff[i] && pwm_val_ff[i] != 16'h0000)
               pwm_run_ff[i] <= 1'b1;
         end
      end
   end

   // output drive: mapping, then static level, then pwm
   logic [NUM_OUT-1:0] relay_out_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         relay_out_ff <= '0;
      end else begin
         for (int i = 0; i < NUM_OUT; i++) begin
            if (i < NUM_IN && map_en_ff[i] && !restore) begin
               if (map_tog_ff[i]) begin
                  if (rise[i]) relay_out_ff[i] <= ~relay_out_ff[i];
               end else begin
                  relay_out_ff[i] <= in_state_ff[i] ^ map_inv_ff[i];
               end
            end else if (out_level_ff[i]) begin
               relay_out_ff[i] <= 1'b1;
            end else if (pwm_run_ff[i]) begin
               relay_out_ff[i] <= (cyc_cnt_ff < pwm_val_ff[i]);
            end else begin
               relay_out_ff[i] <= 1'b0;
            end
         end
      end
   end

   // transmit queue count; full queue drops the byte
   logic [TQW-1:0] txq_ff;
   logic tx_push_ff;
   logic [7:0] tx_data_ff;
   logic tx_take;
   always_comb tx_take = wr_at(GIO_A_TX_DATA) && (txq_ff != TQ_FULL);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txq_ff <= '0;
         tx_push_ff <= 1'b0;
         tx_data_ff <= 8'h00;
      end else begin
         tx_push_ff <= tx_take;
         if (tx_take) tx_data_ff <= reg_wdata[7:0];
         if (tx_take && !(ser_byte_sent && txq_ff != '0))
            txq_ff <= txq_ff + TQW'(1);
         else if (!tx_take && ser_byte_sent && txq_ff != '0)
            txq_ff <= txq_ff - TQW'(1);
      end
   end

   // serial settings decode
   logic [2:0] ser_baud_ff;
   logic ser_par_en_ff, ser_par_odd_ff, ser_rtu_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ser_baud_ff <= GIO_BAUD_NONE;
         ser_par_en_ff <= 1'b0;
         ser_par_odd_ff <= 1'b0;
         ser_rtu_ff <= 1'b0;
      end else begin
         ser_baud_ff <= speed_decode(cfg_ff.serial[GIO_SER_SPEED_W-1:0]);
         ser_par_en_ff <= cfg_ff.serial[GIO_SER_PAR_EN];
         ser_par_odd_ff <= cfg_ff.serial[GIO_SER_PAR_ODD];
         ser_rtu_ff <= cfg_ff.serial[GIO_SER_RTU];
      end
   end

   // interrupt cause: sticky, written ones clear, new events win
   logic [3:0] cause_ff, cause_set, cause_clr;
   assign cause_set = {|(rise | fall), ser_rtu_ff && ser_frame_done,
                       ser_tx_done, ser_rx_not_empty};
   always_comb cause_clr = wr_at(GIO_A_IRQ_CAUSE) ? reg_wdata[3:0] : 4'h0;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) cause_ff <= 4'h0;
      else cause_ff <= (cause_ff & ~cause_clr) | cause_set;
   end

   // register reads, one cycle after the strobe
   logic [15:0] rdata_ff;
   logic rvalid_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= reg_rd;
         if (reg_rd) begin
            rdata_ff <= 16'h0000;
            case (reg_addr)
               GIO_A_OUT_LEVEL: rdata_ff <= 16'(out_level_ff);
               GIO_A_IN_STATE: rdata_ff <= 16'(in_state_ff);
               GIO_A_TXQ: rdata_ff <= 16'(txq_ff);
               GIO_A_WD_FLAG: rdata_ff <= {15'h0000, wd_flag_ff};
               GIO_A_REBOOT: rdata_ff <= 16'h0000;
               GIO_A_FW_VER: rdata_ff <= FW_VERSION;
               GIO_A_IO_COUNT: rdata_ff <= {8'(NUM_IN), 8'(NUM_OUT)};
               GIO_A_ANA_SER: rdata_ff <= {4'h0, NUM_AI, NUM_AO, NUM_SER};
               GIO_A_BOARD_REV: rdata_ff <= BOARD_REV;
               GIO_A_SERNO_LO: rdata_ff <= BOARD_SERNO[15:0];
               GIO_A_SERNO_HI: rdata_ff <= BOARD_SERNO[31:16];
               GIO_A_IRQ_CAUSE: rdata_ff <= {12'h000, cause_ff};
               default: begin
                  for (int i = 0; i < NUM_IN; i++)
                     if (reg_addr == GIO_A_TALLY + 8'(i)) rdata_ff <= tally_ff[i];
               end
            endcase
         end
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_rvalid = rvalid_ff;
   assign relay_out = relay_out_ff;
   assign tx_push = tx_push_ff;
   assign tx_data = tx_data_ff;
   assign ser_baud = ser_baud_ff;
   assign ser_parity_en = ser_par_en_ff;
   assign ser_parity_odd = ser_par_odd_ff;
   assign ser_rtu_en = ser_rtu_ff;
   assign single_wire_disable = sw_disable_ff;
   assign watchdog_reboot_flag = wd_flag_ff;

endmodule // gio_ctrl

`default_nettype wire

// ==== gio_ctrl_assertions.sv ====
// gio_ctrl_chk: port-level assertions for the group controller.
// assumes binding to every gio_ctrl instance, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module gio_ctrl_chk
   import gio_pkg::*;
#(
   parameter int MS_CYC = GIO_MS_CYC
) (
   // clock, reset and register port
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   // watched outputs
   input wire logic tx_push,
   input wire logic [7:0] tx_data,
   input wire logic ser_parity_en,
   input wire logic ser_parity_odd,
   input wire logic ser_rtu_en,
   input wire logic single_wire_disable,
   input wire logic watchdog_reboot_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [31:0] idle_ff;
   wire logic cfg_wr = reg_wr && reg_addr == GIO_A_SERIAL_CFG;
   wire logic swd_wr = reg_wr && reg_addr == GIO_A_SW_DISABLE;
   wire logic clr_wr = reg_wr && reg_addr == GIO_A_WD_CLEAR;
   // cycles since the last register access
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         idle_ff <= 32'h0;
      else if (reg_wr || reg_rd)
         idle_ff <= 32'h0;
      else
         idle_ff <= idle_ff + 32'h1;
   end
   property p_parity;
      cfg_wr |-> ##2
         (ser_parity_en == $past(reg_wdata[GIO_SER_PAR_EN], 2)
          && ser_parity_odd == $past(reg_wdata[GIO_SER_PAR_ODD], 2));
   endproperty
   property p_rtu;
      cfg_wr |-> ##2 ser_rtu_en == $past(reg_wdata[GIO_SER_RTU], 2);
   endproperty
   parity_follows_a: assert property (p_parity)
      else $error("parity outputs differ from written config");
   rtu_follows_a: assert property (p_rtu)
      else $error("frame support output differs from config");
   cfg_wo_read_a: assert property (
      reg_rd && reg_addr == GIO_A_SERIAL_CFG |=> reg_rvalid && !reg_rdata)
      else $error("serial config read back nonzero");
   push_cause_a: assert property (
      tx_push |-> $past(reg_wr && reg_addr == GIO_A_TX_DATA))
      else $error("byte pushed without a data write");
   push_data_a: assert property (
      tx_push |-> tx_data == $past(reg_wdata[7:0]))
      else $error("pushed byte differs from written byte");
   wire_off_set_a: assert property (
      swd_wr && reg_wdata[0] |-> ##[1:2] single_wire_disable)
      else $error("single wire bus not disabled by write");
   wire_off_cause_a: assert property (
      $changed(single_wire_disable) |-> $past(swd_wr) || $past(swd_wr, 2))
      else $error("single wire disable changed without write");
   wd_flag_idle_a: assert property (
      $rose(watchdog_reboot_flag) |-> idle_ff >= MS_CYC - 1)
      else $error("watchdog flag set before timeout");
   wd_flag_clear_a: assert property (
      $fell(watchdog_reboot_flag) |-> $past(clr_wr) || $past(clr_wr, 2))
      else $error("watchdog flag cleared without write");
   cover property (tx_push);
   cover property ($rose(watchdog_reboot_flag));
   cover property (ser_rtu_en && ser_parity_en);
endmodule // gio_ctrl_chk

bind gio_ctrl gio_ctrl_chk #(.MS_CYC(MS_CYC)) u_chk (.clk(clk),
   .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .tx_push(tx_push), .tx_data(tx_data), .ser_parity_en(ser_parity_en),
   .ser_parity_odd(ser_parity_odd), .ser_rtu_en(ser_rtu_en),
   .single_wire_disable(single_wire_disable),
   .watchdog_reboot_flag(watchdog_reboot_flag));
`default_nettype wire

// ==== gio_pkg.sv ====
// gio_pkg: constants, register indices and setting types of the group
// i/o function controller. assumes one 40 mhz clock serves as timebase.
package gio_pkg;

   // timebase
   localparam int GIO_CLK_MHZ = 40;
   localparam int GIO_DEB_UNIT_NS = 100000;
   localparam int GIO_DEB_TICK_CYC = (GIO_DEB_UNIT_NS * GIO_CLK_MHZ + 999) / 1000;
   localparam int GIO_MS_NS = 1000000;
   localparam int GIO_MS_CYC = GIO_MS_NS * GIO_CLK_MHZ / 1000;

   // register indices (word addresses)
   localparam logic [7:0] GIO_A_OUT_LEVEL = 8'h00;
   localparam logic [7:0] GIO_A_IN_STATE = 8'h01;
   localparam logic [7:0] GIO_A_PWM_EN = 8'h02;
   localparam logic [7:0] GIO_A_MAP_EN = 8'h03;
   localparam logic [7:0] GIO_A_MAP_INV = 8'h04;
   localparam logic [7:0] GIO_A_MAP_TOG = 8'h05;
   localparam logic [7:0] GIO_A_DEBOUNCE = 8'h06;
   localparam logic [7:0] GIO_A_PRESCALE = 8'h07;
   localparam logic [7:0] GIO_A_CYCLE = 8'h08;
   localparam logic [7:0] GIO_A_SERIAL_CFG = 8'h09;
   localparam logic [7:0] GIO_A_TXQ = 8'h0A;
   localparam logic [7:0] GIO_A_TX_DATA = 8'h0B;
   localparam logic [7:0] GIO_A_SW_DISABLE = 8'h0C;
   localparam logic [7:0] GIO_A_WD_EN = 8'h0D;
   localparam logic [7:0] GIO_A_WD_TIMEOUT = 8'h0E;
   localparam logic [7:0] GIO_A_WD_FLAG = 8'h0F;
   localparam logic [7:0] GIO_A_WD_CLEAR = 8'h10;
   localparam logic [7:0] GIO_A_REBOOT = 8'h11;
   localparam logic [7:0] GIO_A_SAVE = 8'h12;
   localparam logic [7:0] GIO_A_FW_VER = 8'h13;
   localparam logic [7:0] GIO_A_IO_COUNT = 8'h14;
   localparam logic [7:0] GIO_A_ANA_SER = 8'h15;
   localparam logic [7:0] GIO_A_BOARD_REV = 8'h16;
   localparam logic [7:0] GIO_A_SERNO_LO = 8'h17;
   localparam logic [7:0] GIO_A_SERNO_HI = 8'h18;
   localparam logic [7:0] GIO_A_IRQ_CAUSE = 8'h19;
   localparam logic [7:0] GIO_A_PWM_VAL = 8'h20;
   localparam logic [7:0] GIO_A_TALLY = 8'h28;
   localparam logic [7:0] GIO_A_PRESET = 8'h30;

   // serial configuration fields
   localparam int GIO_SER_SPEED_W = 13;
   localparam int GIO_SER_PAR_EN = 13;
   localparam int GIO_SER_PAR_ODD = 14;
   localparam int GIO_SER_RTU = 15;

   // interrupt cause bit positions
   localparam int GIO_IRQ_RX = 0;
   localparam int GIO_IRQ_TXDONE = 1;
   localparam int GIO_IRQ_FRAME = 2;
   localparam int GIO_IRQ_INPUT = 3;

   // reset values
   localparam logic [15:0] GIO_RST_DEBOUNCE = 16'h0000;
   localparam logic [15:0] GIO_RST_PRESCALE = 16'h0000;
   localparam logic [15:0] GIO_RST_CYCLE = 16'h00FF;
   localparam logic [15:0] GIO_RST_SERIAL = 16'h000D;
   localparam logic [15:0] GIO_RST_WD_TIMEOUT = 16'h03E8;

   typedef enum logic [2:0] {
      GIO_BAUD_NONE = 3'b000,
      GIO_BAUD_2400 = 3'b001,
      GIO_BAUD_4800 = 3'b010,
      GIO_BAUD_9600 = 3'b011,
      GIO_BAUD_19200 = 3'b100,
      GIO_BAUD_38400 = 3'b101,
      GIO_BAUD_57600 = 3'b110,
      GIO_BAUD_115200 = 3'b111
   } gio_baud_t;

   // settings shared by the whole group, saved and restored as one
   typedef struct packed {
      logic [15:0] debounce;
      logic [15:0] prescale;
      logic [15:0] cycle;
      logic [15:0] serial;
   } gio_cfg_t;

   localparam gio_cfg_t GIO_RST_CFG = '{GIO_RST_DEBOUNCE, GIO_RST_PRESCALE,
                                        GIO_RST_CYCLE, GIO_RST_SERIAL};

endpackage

// ==== tb_top.sv ====
// tb_top: register-level tests of gio_ctrl.
// assumes 1 ms shortened to 40 clocks and a 4-byte transmit queue.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import gio_pkg::*;
();
   localparam logic [15:0] CODES [8] = '{16'h000B, 16'h000C, 16'h000D,
      16'h000E, 16'h000F, 16'h1001, 16'h1002, 16'h0001};
   localparam gio_baud_t BDS [8] = '{GIO_BAUD_2400, GIO_BAUD_4800,
      GIO_BAUD_9600, GIO_BAUD_19200, GIO_BAUD_38400, GIO_BAUD_57600,
      GIO_BAUD_115200, GIO_BAUD_NONE};
   logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [3:0] switch_in = 4'h0;
   logic ser_rx_not_empty = 1'b0, ser_tx_done = 1'b0;
   logic ser_byte_sent = 1'b0, ser_frame_done = 1'b0;
   logic [15:0] reg_rdata;
   logic [3:0] relay_out;
   logic [7:0] tx_data;
   logic [2:0] ser_baud;
   logic reg_rvalid, tx_push, ser_parity_en, ser_parity_odd, ser_rtu_en;
   logic single_wire_disable, watchdog_reboot_flag;
   int bad_count = 0, n_tests = 0;
   gio_ctrl #(.TXQ_DEPTH(4), .MS_CYC(40)) DUT (.clk, .reset_n, .reg_wr,
      .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .switch_in,
      .relay_out, .ser_rx_not_empty, .ser_tx_done, .ser_byte_sent,
      .ser_frame_done, .tx_push, .tx_data, .ser_baud, .ser_parity_en,
      .ser_parity_odd, .ser_rtu_en, .single_wire_disable,
      .watchdog_reboot_flag);
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, exp);
   endtask
   task automatic ser_pulse(input logic [3:0] m);
      @(posedge clk);
      {ser_rx_not_empty, ser_byte_sent, ser_tx_done, ser_frame_done} <= m;
      @(posedge clk);
      {ser_rx_not_empty, ser_byte_sent, ser_tx_done, ser_frame_done} <= 4'h0;
   endtask
   task automatic sw(input int i, input logic v, input int n);
      @(posedge clk);
      switch_in[i] <= v;
      settle(n);
   endtask
   // count high cycles of output 2 over eight whole periods
   task automatic hi_cnt(input logic [15:0] exp);
      logic [15:0] n;
      settle(12);
      n = 16'h0000;
      repeat (64) begin
         @(negedge clk);
         n = n + {15'h0, relay_out[2]};
      end
      chk(n, exp);
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      finish_test();
   end
   initial begin
      logic r;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      settle(2);
      chk(ser_baud, GIO_BAUD_9600);
      chk(single_wire_disable, 16'h0000);
      wr(GIO_A_SW_DISABLE, 16'h0001);
      settle(3);
      chk(single_wire_disable, 16'h0001);
      for (int i = 0; i < 8; i++) begin
         wr(GIO_A_SERIAL_CFG, CODES[i] | {1'b0, i[1:0], 13'h0});
         settle(3);
         chk(ser_baud, BDS[i]);
         chk({ser_parity_odd, ser_parity_en}, i[1:0]);
      end
      rdc(GIO_A_SERIAL_CFG, 16'h0000);
      wr(GIO_A_SERIAL_CFG, 16'h800D);
      ser_pulse(4'hB);
      rdc(GIO_A_IRQ_CAUSE, 16'h0007);
      wr(GIO_A_IRQ_CAUSE, 16'h000F);
      rdc(GIO_A_IRQ_CAUSE, 16'h0000);
      for (int i = 0; i < 6; i++)
         wr(GIO_A_TX_DATA, 16'h00A0 + i[15:0]);
      rdc(GIO_A_TXQ, 16'h0004);
      ser_pulse(4'h4);
      rdc(GIO_A_TXQ, 16'h0003);
      wr(GIO_A_PRESET, 16'hFFFF);
      rdc(GIO_A_TALLY, 16'hFFFF);
      sw(0, 1'b1, 4100);
      rdc(GIO_A_IN_STATE, 16'h0001);
      rdc(GIO_A_TALLY, 16'h0000);
      wr(GIO_A_IRQ_CAUSE, 16'h000F);
      wr(GIO_A_DEBOUNCE, 16'h0002);
      sw(1, 1'b1, 4000);
      sw(1, 1'b0, 12100);
      rdc(GIO_A_TALLY + 8'h01, 16'h0000);
      sw(1, 1'b1, 12100);
      rdc(GIO_A_TALLY + 8'h01, 16'h0001);
      rdc(GIO_A_IRQ_CAUSE, 16'h0008);
      wr(GIO_A_DEBOUNCE, 16'h0000);
      wr(GIO_A_MAP_TOG, 16'h0002);
      wr(GIO_A_MAP_INV, 16'h0001);
      wr(GIO_A_MAP_EN, 16'h0003);
      settle(3);
      chk(relay_out[0], 16'h0000);
      r = relay_out[1];
      sw(1, 1'b0, 4100);
      chk(relay_out[1], {15'h0, r});
      sw(1, 1'b1, 4100);
      chk(relay_out[1], {15'h0, ~r});
      wr(GIO_A_MAP_INV, 16'h0000);
      settle(3);
      chk(relay_out[0], 16'h0001);
      wr(GIO_A_MAP_INV, 16'h0001);
      wr(GIO_A_MAP_EN, 16'h0002);
      wr(GIO_A_OUT_LEVEL, 16'h0001);
      settle(3);
      chk(relay_out[0], 16'h0001);
      wr(GIO_A_PRESCALE, 16'h0001);
      wr(GIO_A_CYCLE, 16'h0003);
      wr(GIO_A_PWM_VAL + 8'h02, 16'h0001);
      wr(GIO_A_PWM_EN, 16'h0004);
      wr(GIO_A_OUT_LEVEL, 16'h0005);
      wr(GIO_A_OUT_LEVEL, 16'h0001);
      hi_cnt(16'h0010);
      wr(GIO_A_PWM_VAL + 8'h02, 16'h0009);
      hi_cnt(16'h0030);
      wr(GIO_A_OUT_LEVEL, 16'h0005);
      hi_cnt(16'h0040);
      wr(GIO_A_OUT_LEVEL, 16'h0008);
      wr(GIO_A_SAVE, 16'h0001);
      wr(GIO_A_OUT_LEVEL, 16'h0000);
      wr(GIO_A_REBOOT, 16'h0001);
      rdc(GIO_A_OUT_LEVEL, 16'h0008);
      wr(GIO_A_OUT_LEVEL, 16'h0000);
      wr(GIO_A_WD_TIMEOUT, 16'h0001);
      wr(GIO_A_WD_EN, 16'h0001);
      settle(60);
      chk(watchdog_reboot_flag, 16'h0001);
      rdc(GIO_A_OUT_LEVEL, 16'h0008);
      wr(GIO_A_WD_EN, 16'h0000);
      wr(GIO_A_WD_CLEAR, 16'h0001);
      rdc(GIO_A_WD_FLAG, 16'h0000);
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
